// ---- rtl/spi_master_quirks.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_consts.svh"

module spi_master_quirks
  import spi_master_pkg::*;
#(
  parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_n_in,
  // Mode and control
  input  wire logic                   master_select_bit_in,
  input  wire logic                   fixed_mode_in,
  input  wire logic [`SPI_CS_W-1:0]   fixed_cs_in,
  input  wire logic                   software_reset_bit_in,
  // Per chip-select configuration write
  input  wire logic                   cfg_write_in,
  input  wire logic [`SPI_CS_W-1:0]   cfg_cs_in,
  input  wire logic [`SPI_DIV_W-1:0]  serial_clock_divider_in,
  input  wire logic                   clock_polarity_in,
  input  wire logic                   clock_phase_inverted_in,
  input  wire logic [`SPI_BITS_W-1:0] bits_code_in,
  input  wire logic                   keep_cs_after_transfer_in,
  // Transmit data from processor or DMA
  input  wire logic                   tx_valid_in,
  input  wire logic [`SPI_WORD_W-1:0] transmit_data_reg_in,
  output var  logic                   tx_ready_out,
  output var  logic                   dma_halfword_out,
  // Status
  output var  logic                   transmit_ready_out,
  output var  logic                   transmit_empty_out,
  output var  logic [`SPI_DATA_W-1:0] rx_data_out,
  output var  logic                   rx_valid_out,
  // Serial pins
  output var  logic                   serial_clock_pin_out,
  output var  logic                   mosi_out,
  input  wire logic                   miso_in,
  output var  logic [`SPI_NUM_CS-1:0] cs_n_out
);
  localparam int NCS = `SPI_NUM_CS;

  // Per chip-select configuration sets
  logic [`SPI_DIV_W-1:0]  div_q  [NCS];
  logic                   pol_q  [NCS];
  logic                   pha_q  [NCS];
  logic [`SPI_BITS_W-1:0] bits_q [NCS];
  logic                   keep_q [NCS];

  spi_state_t             state_q;
  logic [`SPI_CS_W-1:0]   cur_cs_q;
  logic [`SPI_CS_W-1:0]   prev_cs_q;
  logic                   prev_slow_q;
  logic                   hold_q;
  logic                   idle_seen_q;
  logic                   repeat_q;
  logic                   last_q;
  logic [`SPI_DATA_W-1:0] shift_q;
  logic [`SPI_DATA_W-1:0] rx_q;
  logic [4:0]             nbits_q;
  logic [5:0]             half_q;
  logic [5:0]             halves_q;
  logic [`SPI_DIV_W-1:0]  div_cnt_q;
  logic                   miso_meta_q;
  logic                   miso_sync_q;

  logic                   fifo_valid;
  logic [`SPI_WORD_W-1:0] fifo_word;
  logic                   fifo_pop;
  logic [`SPI_CS_W-1:0]   sel_cs;
  logic                   sel_div1;
  logic                   sel_odd;
  logic [4:0]             sel_nbits;
  logic                   quirk_repeat;
  logic                   quirk_extra;
  logic                   start;
  logic                   half_tick;
  logic [4:0]             bit_idx;

  spi_tx_fifo #(
    .WIDTH (`SPI_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (software_reset_bit_in),
    .in_valid_in   (tx_valid_in),
    .in_data_in    (transmit_data_reg_in),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_word),
    .out_ready_in  (fifo_pop)
  );

  // Two-stage synchroniser on the slave's data line
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      miso_meta_q <= 1'b0;
      miso_sync_q <= 1'b0;
    end
    else
    begin
      miso_meta_q <= miso_in;
      miso_sync_q <= miso_meta_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < NCS; i++)
      begin
        div_q[i]  <= `SPI_DIV_RESET;
        pol_q[i]  <= 1'b0;
        pha_q[i]  <= 1'b0;
        bits_q[i] <= `SPI_BITS_RESET;
        keep_q[i] <= 1'b0;
      end
    end
    else if (cfg_write_in)
    begin
      div_q[cfg_cs_in]  <= serial_clock_divider_in;
      pol_q[cfg_cs_in]  <= clock_polarity_in;
      pha_q[cfg_cs_in]  <= clock_phase_inverted_in;
      bits_q[cfg_cs_in] <= bits_code_in;
      keep_q[cfg_cs_in] <= keep_cs_after_transfer_in;
    end
  end

  // Select decode for the word at the FIFO head
  assign sel_cs    = fixed_mode_in ? fixed_cs_in
                                   : fifo_word[`SPI_CS_HI:`SPI_CS_LO];
  assign sel_div1  = div_q[sel_cs] == `SPI_DIV_W'(1);
  assign sel_nbits = 5'(bits_q[sel_cs]) + 5'(`SPI_BITS_BASE);
  assign sel_odd   = sel_nbits[0];
  assign start     = state_q == ST_IDLE && fifo_valid && master_select_bit_in;

  // the repeat condition leaves the head word in the FIFO
  assign quirk_repeat = keep_q[sel_cs] && sel_div1 && hold_q
                        && prev_cs_q == sel_cs && idle_seen_q && !repeat_q;
  assign fifo_pop     = start && !quirk_repeat;

  // conditions that add one clock pulse
  assign quirk_extra = (sel_div1 && sel_odd)
                       || (pol_q[sel_cs] && !pha_q[sel_cs] && sel_div1
                           && prev_slow_q);

  assign half_tick = state_q == ST_SHIFT && div_cnt_q == '0;
  assign bit_idx   = 5'(half_q >> 1);

  // Transfer sequencing and shifter
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q   <= ST_IDLE;
      cur_cs_q  <= '0;
      last_q    <= 1'b0;
      shift_q   <= '0;
      rx_q      <= '0;
      nbits_q   <= '0;
      half_q    <= '0;
      halves_q  <= '0;
      div_cnt_q <= '0;
      repeat_q  <= 1'b0;
    end
    else if (software_reset_bit_in)
    begin
      state_q  <= ST_IDLE;
      repeat_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            state_q   <= ST_SHIFT;
            cur_cs_q  <= sel_cs;
            last_q    <= fifo_word[`SPI_LAST_BIT];
            shift_q   <= fifo_word[`SPI_DATA_W-1:0] << (5'd16 - sel_nbits);
            nbits_q   <= sel_nbits;
            half_q    <= '0;
            halves_q  <= 6'({sel_nbits, 1'b0}) + (quirk_extra ? 6'd2 : 6'd0);
            div_cnt_q <= div_q[sel_cs] - `SPI_DIV_W'(1);
            repeat_q  <= quirk_repeat;
          end
        end
        ST_SHIFT:
        begin
          if (half_tick)
          begin
            div_cnt_q <= div_q[cur_cs_q] - `SPI_DIV_W'(1);
            half_q    <= half_q + 6'd1;
            // Pulses beyond the word carry no data
            if (bit_idx < nbits_q)
            begin
              if (!half_q[0])
                rx_q <= {rx_q[`SPI_DATA_W-2:0], miso_sync_q};
              else
                shift_q <= shift_q << 1;
            end
            if (half_q == halves_q - 6'd1)
              state_q <= ST_DONE;
          end
          else
            div_cnt_q <= div_cnt_q - `SPI_DIV_W'(1);
        end
        ST_DONE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Select hold and history for the back-to-back quirks
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      hold_q      <= 1'b0;
      prev_cs_q   <= '0;
      prev_slow_q <= 1'b0;
      idle_seen_q <= 1'b0;
      cs_n_out    <= '1;
    end
    else if (software_reset_bit_in)
    begin
      hold_q      <= 1'b0;
      idle_seen_q <= 1'b0;
      cs_n_out    <= '1;
    end
    else
    begin
      if (start)
      begin
        cs_n_out          <= '1;
        cs_n_out[sel_cs]  <= 1'b0;
        idle_seen_q       <= 1'b0;
      end
      else if (state_q == ST_IDLE && !fifo_valid)
        idle_seen_q <= 1'b1;
      if (state_q == ST_DONE)
      begin
        prev_cs_q   <= cur_cs_q;
        prev_slow_q <= div_q[cur_cs_q] != `SPI_DIV_W'(1);
        // last flag or keep clear drops select, whether or not the FIFO is empty
        if (!keep_q[cur_cs_q] || last_q)
        begin
          hold_q   <= 1'b0;
          cs_n_out <= '1;
        end
        else
          hold_q <= 1'b1;
      end
    end
  end

  // Pins and status, all registered
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      serial_clock_pin_out <= 1'b0;
      mosi_out             <= 1'b0;
      transmit_ready_out   <= 1'b1;
      transmit_empty_out   <= 1'b1;
      rx_valid_out         <= 1'b0;
      rx_data_out          <= '0;
      dma_halfword_out     <= 1'b0;
    end
    else
    begin
      // idle level follows config writes, even before master mode
      if (state_q == ST_SHIFT)
      begin
        if (half_tick)
          serial_clock_pin_out <= ~serial_clock_pin_out;
      end
      else if (cfg_write_in)
        serial_clock_pin_out <= clock_polarity_in;
      else if (master_select_bit_in)
        serial_clock_pin_out <= pol_q[cur_cs_q];
      mosi_out <= shift_q[`SPI_DATA_W-1];
      // no ready rise on a repeated load
      if (start)
        transmit_ready_out <= !quirk_repeat;
      else if (state_q == ST_IDLE && !fifo_valid)
        transmit_ready_out <= 1'b1;
      transmit_empty_out <= state_q != ST_SHIFT && !fifo_valid && !start;
      rx_valid_out       <= state_q == ST_DONE;
      if (state_q == ST_DONE)
        rx_data_out <= rx_q;
      // fixed mode sizes DMA from select zero
      if (fixed_mode_in)
        dma_halfword_out <= bits_q[0] != `SPI_BITS_RESET;
      else
        dma_halfword_out <= sel_nbits != 5'(`SPI_BITS_BASE);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/spi_master_consts.svh ----
`ifndef SPI_MASTER_CONSTS_SVH
`define SPI_MASTER_CONSTS_SVH

// Transmit word layout
`define SPI_WORD_W          32
`define SPI_DATA_W          16
`define SPI_LAST_BIT        24
`define SPI_CS_LO           16
`define SPI_CS_HI           17
// Chip selects and per-select configuration
`define SPI_NUM_CS          4
`define SPI_CS_W            2
`define SPI_DIV_W           8
`define SPI_BITS_W          4
`define SPI_BITS_BASE       8
`define SPI_DIV_RESET       8'h02
`define SPI_BITS_RESET      4'h0
// Transmit FIFO
`define SPI_FIFO_DEPTH      16

`endif

// ---- rtl/spi_master_pkg.sv ----
package spi_master_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } spi_state_t;
endpackage

// ---- rtl/spi_tx_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_tx_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output var  logic             in_ready_out,
  // Drain side
  output var  logic             out_valid_out,
  output var  logic [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  assign out_data_out = mem_q[rd_q];

  // Occupancy; ready and valid are registered from the next count
  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + (AW+1)'(1);
    else if (pop && !push)
      count_d = count_q - (AW+1)'(1);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_q       <= '0;
      wr_q          <= '0;
      rd_q          <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else if (flush_in)
    begin
      count_q       <= '0;
      wr_q          <= '0;
      rd_q          <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else
    begin
      count_q       <= count_d;
      in_ready_out  <= count_d != (AW+1)'(DEPTH);
      out_valid_out <= count_d != '0;
      if (push)
        wr_q <= wr_q + AW'(1);
      if (pop)
        rd_q <= rd_q + AW'(1);
    end
  end

  // Storage has no reset; the head slot is read even while the count is zero
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end
endmodule
`default_nettype wire

// ---- bench/spi_master_quirks_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_consts.svh"
module spi_master_quirks_properties (
  // Clock, reset and mode
  input wire logic                   clk_sys_in,
  input wire logic                   reset_n_in,
  input wire logic                   master_select_bit_in,
  input wire logic                   fixed_mode_in,
  // Configuration and fill side
  input wire logic                   cfg_write_in,
  input wire logic [`SPI_CS_W-1:0]   cfg_cs_in,
  input wire logic [`SPI_BITS_W-1:0] bits_code_in,
  input wire logic                   tx_valid_in,
  input wire logic [`SPI_WORD_W-1:0] transmit_data_reg_in,
  // Outputs watched
  input wire logic                   tx_ready_out,
  input wire logic                   dma_halfword_out,
  input wire logic                   transmit_empty_out,
  input wire logic                   rx_valid_out,
  input wire logic                   serial_clock_pin_out,
  input wire logic [`SPI_NUM_CS-1:0] cs_n_out
);
  logic [`SPI_BITS_W-1:0] b0_q;
  logic                   last_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Shadow of select zero bit count; software reset keeps it too
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in)
      b0_q <= `SPI_BITS_RESET;
    else if (cfg_write_in && cfg_cs_in == 2'h0)
      b0_q <= bits_code_in;
  // Last flag of the newest word, which is the last one shifted
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in)
      last_q <= 1'b0;
    else if (tx_valid_in && tx_ready_out)
      last_q <= transmit_data_reg_in[`SPI_LAST_BIT];
  property p_halfword;
    (fixed_mode_in && !cfg_write_in)[*3]
      |-> dma_halfword_out == (b0_q != 4'h0);
  endproperty
  a_halfword: assert property (p_halfword)
    else $error("dma size not from select zero");
  property p_idle_clock;
    !master_select_bit_in && !(cfg_write_in || $past(cfg_write_in))
      && &cs_n_out |=> $stable(serial_clock_pin_out);
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("idle clock moved without cause");
  property p_release;
    fixed_mode_in && last_q && $rose(transmit_empty_out)
      |-> ##[0:2] &cs_n_out;
  endproperty
  a_release: assert property (p_release)
    else $error("select held after last word");
  property p_one_select;
    $onehot0(~cs_n_out);
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("two selects low");
  property p_rx_pulse;
    rx_valid_out |=> !rx_valid_out;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive strobe too long");
  property p_empty_ready;
    transmit_empty_out |-> tx_ready_out;
  endproperty
  a_empty_ready: assert property (p_empty_ready)
    else $error("empty but fill side not ready");
  property p_master;
    !master_select_bit_in && &cs_n_out |=> &cs_n_out;
  endproperty
  a_master: assert property (p_master)
    else $error("transfer started without master");
endmodule
`default_nettype wire

// ---- bench/spi_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_consts.svh"
module spi_slave_model (
  // Serial pins at the slave
  input  wire logic                   serial_clock_pin_in,
  input  wire logic [`SPI_NUM_CS-1:0] cs_n_in,
  output var  logic                   miso_out,
  // Clock edges seen in the last finished frame
  output var  logic [7:0]             frame_edges_out
);
  logic [7:0] edges_q;
  logic       idle;
  assign idle = &cs_n_in;
  initial
  begin
    edges_q = 8'h00;
    miso_out = 1'b0;
    frame_edges_out = 8'h00;
  end
  // Count every clock edge in a frame and move the reply bit on every second one
  always @(serial_clock_pin_in)
    if (!idle)
    begin
      edges_q = edges_q + 8'h01;
      miso_out = edges_q[1];
    end
  // Released line flips so a stale level never reads as data
  always @(posedge idle)
  begin
    frame_edges_out = edges_q;
    miso_out = ~miso_out;
  end
  always @(negedge idle)
    edges_q = 8'h00;
endmodule
`default_nettype wire

// ---- bench/spi_master_quirks_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_consts.svh"
module spi_master_quirks_tb;
  logic        clk_sys_in, reset_n_in, master_select_bit_in, fixed_mode_in;
  logic [1:0]  fixed_cs_in, cfg_cs_in;
  logic        software_reset_bit_in, cfg_write_in, clock_polarity_in;
  logic [7:0]  serial_clock_divider_in, frame_edges;
  logic [3:0]  bits_code_in, cs_n_out;
  logic        keep_cs_after_transfer_in, tx_valid_in, tx_ready_out;
  logic [31:0] transmit_data_reg_in;
  logic        dma_halfword_out, transmit_ready_out, transmit_empty_out;
  logic        rx_valid_out, serial_clock_pin_out, mosi_out, miso_in;
  int          num_errors, n_tests, rx_cnt;
  // Divider, bits code, expected clock edges
  localparam logic [19:0] rows [6] = '{20'h01010, 20'h01114, 20'h01214,
                                       20'h01720, 20'h01820, 20'h03112};
  spi_master_quirks #(.FIFO_DEPTH(16)) uut (.clk_sys_in, .reset_n_in,
    .master_select_bit_in, .fixed_mode_in, .fixed_cs_in,
    .software_reset_bit_in, .cfg_write_in, .cfg_cs_in,
    .serial_clock_divider_in, .clock_polarity_in,
    .clock_phase_inverted_in(1'b0), .bits_code_in,
    .keep_cs_after_transfer_in, .tx_valid_in, .transmit_data_reg_in,
    .tx_ready_out, .dma_halfword_out, .transmit_ready_out,
    .transmit_empty_out, .rx_data_out(), .rx_valid_out,
    .serial_clock_pin_out, .mosi_out, .miso_in, .cs_n_out);
  spi_slave_model slave (.serial_clock_pin_in(serial_clock_pin_out),
    .cs_n_in(cs_n_out), .miso_out(miso_in), .frame_edges_out(frame_edges));
  always #10 clk_sys_in = ~clk_sys_in;
  // Count receive strobes as seen at the clock edge
  always @(posedge clk_sys_in)
    if (rx_valid_out === 1'b1)
      rx_cnt++;
  task automatic check(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg(input logic [1:0] cs, input logic [7:0] dv,
                     input logic pol, input logic [3:0] code, input logic k);
    @(posedge clk_sys_in);
    cfg_write_in <= 1'b1;
    cfg_cs_in <= cs;
    serial_clock_divider_in <= dv;
    clock_polarity_in <= pol;
    bits_code_in <= code;
    keep_cs_after_transfer_in <= k;
    @(posedge clk_sys_in);
    cfg_write_in <= 1'b0;
  endtask
  task automatic push(input logic last, input logic [1:0] cs);
    @(posedge clk_sys_in);
    tx_valid_in <= 1'b1;
    transmit_data_reg_in <= {7'h00, last, 6'h00, cs, 16'ha5c3};
    do @(posedge clk_sys_in); while (tx_ready_out !== 1'b1);
    tx_valid_in <= 1'b0;
  endtask
  task automatic wait_rx(input int n);
    repeat (1000) if (rx_cnt < n) @(posedge clk_sys_in);
    repeat (4) @(posedge clk_sys_in);
    check("rx count", 16'(n), 16'(rx_cnt));
  endtask
  task automatic xfer(input logic [1:0] cs, input logic [7:0] exp);
    push(1'b0, cs);
    wait_rx(rx_cnt + 1);
    if (exp != 8'h00) check("clock edges", {8'h00, exp}, {8'h00, frame_edges});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    conclude();
  end
  initial
  begin
    {clk_sys_in, reset_n_in, master_select_bit_in, fixed_mode_in} = 4'h0;
    {fixed_cs_in, cfg_cs_in, software_reset_bit_in, cfg_write_in} = 6'h00;
    {serial_clock_divider_in, clock_polarity_in, bits_code_in} = 13'h0000;
    {keep_cs_after_transfer_in, tx_valid_in, transmit_data_reg_in} = 34'h0;
    {num_errors, n_tests, rx_cnt} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge clk_sys_in);
    check("reset outputs", 16'h070f, {tx_ready_out, transmit_ready_out,
      transmit_empty_out, dma_halfword_out, serial_clock_pin_out, mosi_out,
      rx_valid_out, cs_n_out});
    reset_n_in <= 1'b1;
    master_select_bit_in <= 1'b1;
    foreach (rows[i])
    begin
      cfg(2'h0, rows[i][19:12], 1'b0, rows[i][11:8], 1'b0);
      xfer(2'h0, rows[i][7:0]);
    end
    // Slow select first settles idle level high, then fast one
    cfg(2'h1, 8'h03, 1'b1, 4'h0, 1'b0);
    cfg(2'h2, 8'h01, 1'b1, 4'h0, 1'b0);
    xfer(2'h1, 8'h00);
    xfer(2'h1, 8'h10);
    xfer(2'h2, 8'h12);
    // Banned combination on purpose: second word goes out twice
    cfg(2'h3, 8'h01, 1'b0, 4'h0, 1'b1);
    xfer(2'h3, 8'h00);
    repeat (6) @(posedge clk_sys_in);
    push(1'b0, 2'h3);
    // Ready must stay low while the unpopped copy is shifting
    repeat (4) @(posedge clk_sys_in);
    check("transmit ready", 16'h0000, {15'h0, transmit_ready_out});
    wait_rx(rx_cnt + 2);
    software_reset_bit_in <= 1'b1;
    @(posedge clk_sys_in);
    software_reset_bit_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    check("selects after reset", 16'h000f, {12'h0, cs_n_out});
    // Held select with DMA through the controller, not general I/O
    fixed_mode_in <= 1'b1;
    fixed_cs_in <= 2'h1;
    cfg(2'h0, 8'h02, 1'b0, 4'h2, 1'b0);
    cfg(2'h1, 8'h02, 1'b0, 4'h0, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    check("dma size", 16'h0001, {15'h0, dma_halfword_out});
    xfer(2'h0, 8'h00);
    check("held select", 16'h000d, {12'h0, cs_n_out});
    push(1'b1, 2'h0);
    wait_rx(rx_cnt + 1);
    check("released select", 16'h000f, {12'h0, cs_n_out});
    fixed_mode_in <= 1'b0;
    // Fill the buffer with master off until it refuses, then drain
    master_select_bit_in <= 1'b0;
    cfg(2'h0, 8'h02, 1'b0, 4'h0, 1'b0);
    repeat (16) push(1'b0, 2'h0);
    repeat (2) @(posedge clk_sys_in);
    check("buffer full", 16'h0000, {15'h0, tx_ready_out});
    master_select_bit_in <= 1'b1;
    wait_rx(rx_cnt + 16);
    check("drained", 16'h0001, {15'h0, transmit_empty_out});
    conclude();
  end
endmodule
bind spi_master_quirks spi_master_quirks_properties u_props (.clk_sys_in,
  .reset_n_in, .master_select_bit_in, .fixed_mode_in, .cfg_write_in,
  .cfg_cs_in, .bits_code_in, .tx_valid_in, .transmit_data_reg_in,
  .tx_ready_out, .dma_halfword_out, .transmit_empty_out, .rx_valid_out,
  .serial_clock_pin_out, .cs_n_out);
`default_nettype wire
